// File: include/cfec_defines.svh
`ifndef CFEC_DEFINES_SVH
`define CFEC_DEFINES_SVH

// Privileged register selects
`define CFEC_SEL_FILL_ADDR  3'h1
`define CFEC_SEL_FILL_CHK   3'h2
`define CFEC_SEL_TAG_SNAP   3'h3
`define CFEC_SEL_FILL_STAT  3'h4
`define CFEC_SEL_SCRATCH    3'h5

// Fill error address field
`define CFEC_ADDR_LSB       2
`define CFEC_ADDR_MSB       33
`define CFEC_ADDR_W         32

// Check-pattern and fill-status layout
`define CFEC_CHK_W          14
`define CFEC_SYN_W          7
`define CFEC_CHK_HI_LSB     7
`define CFEC_FSTAT_LSB      8

// Snapshot, scratch and pin-synchroniser sizing
`define CFEC_TAG_MAX        29
`define CFEC_TAG_DEF        21
`define CFEC_SCRATCH_N      32
`define CFEC_SYNC_N         3
`define CFEC_PIN_N          5

// Reset values of control state
`define CFEC_LOCK_RST       1'b0

`endif

// File: include/cfec_pkg.sv
`include "cfec_defines.svh"

package cfec_pkg;

  typedef logic [`CFEC_SYN_W-1:0] cfec_syn_t;

  // Fill status bits 14..8, msb first
  typedef struct packed {
    logic       fatal2;
    logic [1:0] qw;
    logic       istream;
    logic       par_flag;
    logic       crd;
    logic       ecc_flag;
  } cfec_fstat_t;

  // Tag snapshot, bit 0 is shifted out first
  typedef struct packed {
    logic                      hit;
    logic                      ctl_par;
    logic                      dirty;
    logic                      shared;
    logic                      valid;
    logic [`CFEC_TAG_MAX-1:0]  tag;
    logic                      adr_par;
  } cfec_snap_t;

  // Single-bit data error codes, index is the data bit
  localparam cfec_syn_t CFEC_SYN_TAB [32] = '{
    7'h4f, 7'h4a, 7'h52, 7'h54, 7'h57, 7'h58, 7'h5b, 7'h5d,
    7'h23, 7'h25, 7'h26, 7'h29, 7'h2a, 7'h2c, 7'h31, 7'h34,
    7'h0e, 7'h0b, 7'h13, 7'h15, 7'h16, 7'h19, 7'h1a, 7'h1c,
    7'h62, 7'h64, 7'h67, 7'h68, 7'h6b, 7'h6d, 7'h70, 7'h75};

  typedef struct packed {
    logic [`CFEC_SYNC_N-1:0][`CFEC_PIN_N-1:0] sync;
    logic [`CFEC_PIN_N-1:0]                   pins;
    logic                                     fill_lock;
    logic                                     tag_lock;
    logic [`CFEC_ADDR_W-1:0]                  faddr;
    logic [`CFEC_CHK_W-1:0]                   chk;
    cfec_fstat_t                              fstat;
    cfec_snap_t                               snap;
    logic [`CFEC_SCRATCH_N-1:0][63:0]         scratch;
    logic [63:0]                              rd_data;
    logic                                     rd_valid;
  } cfec_state_t;

endpackage

// File: src/cfec_top.sv
`timescale 1ns/100ps
`include "cfec_defines.svh"
// Notes on behaviour
// - Fill error address is read-only, valid while a fill error flag is set.
// - Reading fill address unlocks it, fill status and check pattern.
// - Address bits 33:5 name the 32-byte block being fetched.
// - Bits 4:2 hold load address bits on data fills, unpredictable otherwise.
// - Fill address bits 63:34 and 1:0 read as zero.
// - Check-pattern register is read-only with 14 meaningful bits.
// - ECC mode: fill ECC error captures and locks the quadword syndromes.
// - Lower longword syndrome in bits 6:0, upper in bits 13:7.
// - Zero syndrome means that longword had no error.
// - Single-bit errors give fixed codes; check bits give one-hot codes.
// - Parity mode: bit 0 marks bad lower longword, bit 7 bad upper.
// - Parity mode: check-pattern bits 13:8 and 6:1 read zero.
// - Unlocked tag snapshot reloads on every off-chip tag probe.
// - Snapshot locks on tag, tag-control or fill data error.
// - Snapshot read returns bit 0, then shifts right one place.
// - Writing the snapshot register unlocks it.
// - Tag bits unused for the configured cache size read clear.
// - Snapshot captures tag pins at a probe or fill error, hit flag only at a probe.
// - Tag field holds the tag currently probed.
// - Thirty-two 64-bit scratch registers reached by privileged moves.
// - Fill error locks fill status and latches the failing address.
module cfec_top #(
  parameter int TAG_W = `CFEC_TAG_DEF
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        priv_rd,
  input  wire logic                        priv_wr,
  input  wire logic [2:0]                  priv_sel,
  input  wire logic [4:0]                  scratch_idx,
  input  wire logic [63:0]                 priv_wdata,
  output logic      [63:0]                 priv_rdata,
  output logic                             priv_rvalid,
  input  wire logic                        fill_valid,
  input  wire logic                        fill_ecc_mode,
  input  wire logic                        fill_istream,
  input  wire logic [1:0]                  fill_qw,
  input  wire logic [`CFEC_ADDR_MSB:`CFEC_ADDR_LSB] fill_addr,
  input  wire logic [63:0]                 fill_data,
  input  wire logic [`CFEC_CHK_W-1:0]      fill_check,
  input  wire logic                        probe_valid,
  input  wire logic [TAG_W-1:0]            probe_tag,
  input  wire logic                        probe_hit,
  input  wire logic                        probe_tag_perr,
  input  wire logic                        probe_ctl_perr,
  input  wire logic [2:0]                  offchip_cache_size,
  input  wire logic                        tag_address_parity_pin,
  input  wire logic                        tag_valid_pin,
  input  wire logic                        tag_shared_pin,
  input  wire logic                        tag_dirty_pin,
  input  wire logic                        tag_control_parity_pin,
  output logic                             fill_lock_out,
  output logic                             tag_lock_out
);

  // Elaboration check: the snapshot tag field cannot hold more than CFEC_TAG_MAX bits
  if (TAG_W < 1 || TAG_W > `CFEC_TAG_MAX)
  begin : g_tag_w_bad
    $error("TAG_W out of range");
  end

  cfec_pkg::cfec_state_t s_q;
  cfec_pkg::cfec_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Syndrome generator: columns of the check matrix are the single-bit codes
  function automatic cfec_pkg::cfec_syn_t gen_syn(input logic [31:0] d,
                                                  input cfec_pkg::cfec_syn_t c);
    cfec_pkg::cfec_syn_t s;
    s = c;
    for (int i = 0; i < 32; i++)
    begin
      if (d[i])
        s = s ^ cfec_pkg::CFEC_SYN_TAB[i];
    end
    return s;
  endfunction

  // Zero, one-hot (check bit) or a table code is a single-bit case
  function automatic logic is_corr(input cfec_pkg::cfec_syn_t s);
    logic m;
    m = (s == 7'h00) || $onehot(s);
    for (int i = 0; i < 32; i++)
    begin
      if (s == cfec_pkg::CFEC_SYN_TAB[i])
        m = 1'b1;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Error detection on each incoming fill quadword
  cfec_pkg::cfec_syn_t syn_lo;
  cfec_pkg::cfec_syn_t syn_hi;
  logic                par_lo;
  logic                par_hi;
  logic                ecc_err;
  logic                par_err;
  logic                fill_err;
  logic                multibit;
  logic                fill_rd;
  logic                tag_rd;
  logic                tag_wr;
  logic                tag_lock_ev;
  logic [TAG_W-1:0]    tag_mask;

  assign syn_lo   = gen_syn(fill_data[31:0], fill_check[`CFEC_SYN_W-1:0]);
  assign syn_hi   = gen_syn(fill_data[63:32], fill_check[`CFEC_CHK_W-1:`CFEC_CHK_HI_LSB]);
  assign par_lo   = ^{fill_data[31:0], fill_check[0]};                      // Even parity
  assign par_hi   = ^{fill_data[63:32], fill_check[`CFEC_CHK_HI_LSB]};
  assign ecc_err  = fill_ecc_mode && (syn_lo != 7'h00 || syn_hi != 7'h00);
  assign par_err  = !fill_ecc_mode && (par_lo || par_hi);
  assign fill_err = fill_valid && (ecc_err || par_err);
  assign multibit = ecc_err && !(is_corr(syn_lo) && is_corr(syn_hi));
  assign fill_rd  = priv_rd && priv_sel == `CFEC_SEL_FILL_ADDR;
  assign tag_rd   = priv_rd && priv_sel == `CFEC_SEL_TAG_SNAP;
  assign tag_wr   = priv_wr && priv_sel == `CFEC_SEL_TAG_SNAP;
  assign tag_lock_ev = (probe_valid && (probe_tag_perr || probe_ctl_perr)) || fill_err;
  // Larger caches index deeper, so the low tag bits fall away
  assign tag_mask = {TAG_W{1'b1}} << offchip_cache_size;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;
    s_d.rd_valid = priv_rd;
    s_d.rd_data  = 64'h0;
    // Pin synchroniser; a level is taken once stages two and three agree
    s_d.sync[0] = {tag_control_parity_pin, tag_dirty_pin, tag_shared_pin,
                   tag_valid_pin, tag_address_parity_pin};
    s_d.sync[1] = s_q.sync[0];
    s_d.sync[2] = s_q.sync[1];
    for (int b = 0; b < `CFEC_PIN_N; b++)
    begin
      if (s_q.sync[1][b] == s_q.sync[2][b])
        s_d.pins[b] = s_q.sync[2][b];
    end

    // Register reads, answered one cycle later
    case (priv_sel)
      `CFEC_SEL_FILL_ADDR:
        s_d.rd_data = {30'h0, s_q.faddr, 2'h0};
      `CFEC_SEL_FILL_CHK:
        s_d.rd_data = {50'h0, s_q.chk};
      `CFEC_SEL_TAG_SNAP:
        s_d.rd_data = {63'h0, s_q.snap[0]};
      `CFEC_SEL_FILL_STAT:
        s_d.rd_data = {49'h0, s_q.fstat, 8'h0};
      `CFEC_SEL_SCRATCH:
        s_d.rd_data = s_q.scratch[scratch_idx];
      default:
        s_d.rd_data = 64'h0;
    endcase
    // Idle cycles return zero, so no stale register shows on the bus
    if (!priv_rd)
      s_d.rd_data = 64'h0;

    // Fill address read reopens the fill capture
    if (fill_rd)
    begin
      s_d.fill_lock    = `CFEC_LOCK_RST;
      s_d.fstat.fatal2 = 1'b0;
    end

    // Capture after the unlock, so an error in the reading cycle is kept
    if (fill_err)
    begin
      if (!s_d.fill_lock)
      begin
        s_d.fill_lock      = 1'b1;
        s_d.faddr          = fill_addr;
        s_d.fstat.ecc_flag = ecc_err;
        s_d.fstat.par_flag = par_err;
        s_d.fstat.crd      = ecc_err && !multibit;
        s_d.fstat.istream  = fill_istream;
        s_d.fstat.qw       = fill_qw;
        s_d.fstat.fatal2   = 1'b0;                                           // Nothing stacked yet
        if (fill_ecc_mode)
          s_d.chk = {syn_hi, syn_lo};
        else
          s_d.chk = {6'h0, par_hi, 6'h0, par_lo};
      end
      else if (multibit || par_err)
        s_d.fstat.fatal2 = 1'b1;
    end

    // Serial read-out of the snapshot; locked content shifts too
    if (tag_rd)
      s_d.snap = s_q.snap >> 1;
    if (tag_wr)
      s_d.tag_lock = `CFEC_LOCK_RST;

    // Probe load; an erroring probe is loaded and then held
    if (!s_d.tag_lock)
    begin
      if (probe_valid)
      begin
        s_d.snap.tag = '0;
        s_d.snap.tag[TAG_W-1:0] = probe_tag & tag_mask;
        s_d.snap.hit = probe_hit;
      end
      if (probe_valid || fill_err)
      begin
        s_d.snap.adr_par = s_q.pins[0];
        s_d.snap.valid   = s_q.pins[1];
        s_d.snap.shared  = s_q.pins[2];
        s_d.snap.dirty   = s_q.pins[3];
        s_d.snap.ctl_par = s_q.pins[4];
      end
      if (tag_lock_ev)
        s_d.tag_lock = 1'b1;
    end

    if (priv_wr && priv_sel == `CFEC_SEL_SCRATCH)
      s_d.scratch[scratch_idx] = priv_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; captured error data survives reset on purpose
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s_q.sync      <= '0;
      s_q.pins      <= '0;
      s_q.fill_lock <= `CFEC_LOCK_RST;
      s_q.tag_lock  <= `CFEC_LOCK_RST;
      s_q.rd_data   <= 64'h0;
      s_q.rd_valid  <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign priv_rdata    = s_q.rd_data;
  assign priv_rvalid   = s_q.rd_valid;
  assign fill_lock_out = s_q.fill_lock;
  assign tag_lock_out  = s_q.tag_lock;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_fill_lock_set: assert property (fill_err && !s_q.fill_lock |=> s_q.fill_lock)
    else $error("fill error did not lock");
  a_fill_addr_held: assert property (s_q.fill_lock && !fill_rd |=> $stable(s_q.faddr))
    else $error("locked fill address changed");
  a_fill_addr_cap: assert property (fill_err && !s_q.fill_lock
      |=> s_q.faddr[31:3] == $past(fill_addr[33:5]))
    else $error("fill block address not captured");
  a_fill_unlock: assert property (fill_rd && !fill_err |=> !s_q.fill_lock)
    else $error("fill address read did not unlock");
  a_addr_raz: assert property (fill_rd ##1 priv_rvalid
      |-> priv_rdata[63:34] == 30'h0 && priv_rdata[1:0] == 2'h0)
    else $error("fill address reserved bits set");
  a_chk_raz: assert property (priv_rd && priv_sel == `CFEC_SEL_FILL_CHK
      |=> priv_rdata[63:14] == 50'h0)
    else $error("check pattern upper bits set");
  a_parity_raz: assert property (fill_err && !s_q.fill_lock && !fill_ecc_mode
      |=> s_q.chk[13:8] == 6'h0 && s_q.chk[6:1] == 6'h0 && s_q.chk[0] == $past(par_lo))
    else $error("parity pattern malformed");
  a_parity_upper: assert property (fill_err && !s_q.fill_lock && !fill_ecc_mode
      |=> s_q.chk[7] == $past(par_hi))
    else $error("upper parity flag wrong");
  a_syn_place: assert property (fill_err && !s_q.fill_lock && fill_ecc_mode
      |=> s_q.chk == {$past(syn_hi), $past(syn_lo)})
    else $error("syndrome halves misplaced");
  a_fill_stat_cap: assert property (fill_err && !s_q.fill_lock
      |=> s_q.fstat.ecc_flag == $past(ecc_err) && s_q.fstat.par_flag == $past(par_err))
    else $error("fill status not captured");
  a_fatal_set: assert property (fill_err && s_q.fill_lock && !fill_rd
      && (multibit || par_err) |=> s_q.fstat.fatal2)
    else $error("stacked fill error not flagged");
  a_read_answer: assert property (priv_rd |=> priv_rvalid)
    else $error("read not answered");
  a_rdata_idle: assert property (!priv_rvalid |-> priv_rdata == 64'h0)
    else $error("read data shown outside a read");
  a_tag_lock: assert property (tag_lock_ev && !tag_wr |=> s_q.tag_lock [*2])
    else $error("snapshot failed to lock");
  a_tag_shift: assert property (tag_rd && s_q.tag_lock
      |=> s_q.snap == ($past(s_q.snap) >> 1))
    else $error("snapshot did not shift");
  a_tag_unlock: assert property (tag_wr && !tag_lock_ev |=> !s_q.tag_lock)
    else $error("snapshot write did not unlock");
  a_tag_load: assert property (probe_valid && !s_q.tag_lock
      |=> s_q.snap.hit == $past(probe_hit))
    else $error("probe result not loaded");
  a_tag_mask: assert property (probe_valid && !s_q.tag_lock && !tag_wr
      |=> (s_q.snap.tag[TAG_W-1:0] & ~$past(tag_mask)) == '0)
    else $error("unused tag bits set");

  c_fill_ecc: cover property (fill_err && fill_ecc_mode && !s_q.fill_lock);
  c_fill_parity: cover property (fill_err && !fill_ecc_mode && !s_q.fill_lock);
  c_fill_fatal: cover property (fill_err && s_q.fill_lock && multibit);
  c_tag_serial: cover property (tag_rd ##2 tag_rd ##2 tag_rd);
  c_tag_relock: cover property (tag_wr ##[1:20] tag_lock_ev);

endmodule // cfec_top

// File: testbench/cfec_top_bench.sv
`timescale 1ns/100ps
module cfec_top_bench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        priv_rd = 1'b0;
  logic        priv_wr = 1'b0;
  logic [2:0]  priv_sel = 3'h0;
  logic [4:0]  scratch_idx = 5'h00;
  logic [63:0] priv_wdata = 64'h0;
  logic [63:0] priv_rdata;
  logic        priv_rvalid;
  logic        fill_valid = 1'b0;
  logic        fill_ecc_mode = 1'b1;
  logic        fill_istream = 1'b0;
  logic [1:0]  fill_qw = 2'h0;
  logic [33:2] fill_addr = 32'h0;
  logic [63:0] fill_data = 64'h0;
  logic [13:0] fill_check = 14'h0;
  logic        probe_valid = 1'b0;
  logic [20:0] probe_tag = 21'h0;
  logic        probe_hit = 1'b0;
  logic        probe_tag_perr = 1'b0;
  logic        probe_ctl_perr = 1'b0;
  logic [2:0]  offchip_cache_size = 3'h0;
  logic [4:0]  pins = 5'h0; // Address parity, valid, shared, dirty, control parity
  logic        fill_lock_out;
  logic        tag_lock_out;
  logic [63:0] rd;
  int          fails = 0;
  int          checked = 0;

  ////////////////////////////////////////
  // Clock and device under test
  always #20 core_clk = ~core_clk;

  cfec_top #(.TAG_W(21)) uut (
    .core_clk(core_clk), .reset(reset), .priv_rd(priv_rd), .priv_wr(priv_wr),
    .priv_sel(priv_sel), .scratch_idx(scratch_idx), .priv_wdata(priv_wdata),
    .priv_rdata(priv_rdata), .priv_rvalid(priv_rvalid), .fill_valid(fill_valid),
    .fill_ecc_mode(fill_ecc_mode), .fill_istream(fill_istream), .fill_qw(fill_qw),
    .fill_addr(fill_addr), .fill_data(fill_data), .fill_check(fill_check),
    .probe_valid(probe_valid), .probe_tag(probe_tag), .probe_hit(probe_hit),
    .probe_tag_perr(probe_tag_perr), .probe_ctl_perr(probe_ctl_perr),
    .offchip_cache_size(offchip_cache_size), .tag_address_parity_pin(pins[4]),
    .tag_valid_pin(pins[3]), .tag_shared_pin(pins[2]), .tag_dirty_pin(pins[1]),
    .tag_control_parity_pin(pins[0]), .fill_lock_out(fill_lock_out),
    .tag_lock_out(tag_lock_out));

  ////////////////////////////////////////
  // Shared bus cycles and comparison
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read answer is registered, so it is sampled just after the edge after the request
  task automatic rd_reg(input logic [2:0] sel, input logic [4:0] idx);
    @(posedge core_clk);
    priv_rd <= 1'b1;
    priv_sel <= sel;
    scratch_idx <= idx;
    @(posedge core_clk);
    priv_rd <= 1'b0;
    #1;
    check("read valid", 64'h1, {63'h0, priv_rvalid});
    rd = priv_rdata;
  endtask

  task automatic wr_reg(input logic [2:0] sel, input logic [4:0] idx, input logic [63:0] d);
    @(posedge core_clk);
    priv_wr <= 1'b1;
    priv_sel <= sel;
    scratch_idx <= idx;
    priv_wdata <= d;
    @(posedge core_clk);
    priv_wr <= 1'b0;
    #1;
  endtask

  task automatic fill(input logic ecc, input logic [63:0] d, input logic [13:0] c,
                      input logic [33:2] a);
    @(posedge core_clk);
    fill_valid <= 1'b1;
    fill_ecc_mode <= ecc;
    fill_data <= d;
    fill_check <= c;
    fill_addr <= a;
    fill_qw <= 2'h2;
    @(posedge core_clk);
    fill_valid <= 1'b0;
    #1;
  endtask

  task automatic probe(input logic [20:0] t, input logic h, input logic tp, input logic cp);
    @(posedge core_clk);
    probe_valid <= 1'b1;
    probe_tag <= t;
    probe_hit <= h;
    probe_tag_perr <= tp;
    probe_ctl_perr <= cp;
    @(posedge core_clk);
    probe_valid <= 1'b0;
    probe_tag_perr <= 1'b0;
    probe_ctl_perr <= 1'b0;
    #1;
  endtask

  // Serial read leaves one idle edge between reads, as software must
  task automatic snap(input logic [20:0] t, input logic h);
    logic [34:0] got;
    logic [20:0] tm;
    tm = t & (21'h1fffff << offchip_cache_size);
    for (int i = 0; i < 35; i++)
    begin
      rd_reg(3'h3, 5'h0);
      got[i] = rd[0];
    end
    check("tag snapshot", {29'h0, h, pins[0], pins[1], pins[2], pins[3], 8'h0, tm, pins[4]},
          {29'h0, got});
  endtask

  ////////////////////////////////////////
  // Scenarios
  task automatic test_regs();
    wr_reg(3'h5, 5'h03, 64'hdead_beef_0123_4567);
    wr_reg(3'h5, 5'h1e, 64'h8421_0f0f_5aa5_c33c);
    rd_reg(3'h5, 5'h03);
    check("scratch 3", 64'hdead_beef_0123_4567, rd);
    rd_reg(3'h5, 5'h1e);
    check("scratch 30", 64'h8421_0f0f_5aa5_c33c, rd);
    rd_reg(3'h0, 5'h0);
    check("unmapped 0", 64'h0, rd);
    rd_reg(3'h7, 5'h0);
    check("unmapped 7", 64'h0, rd);
  endtask

  task automatic test_ecc();
    fill(1'b1, 64'h0000_0001_0000_0001, 14'h0, 32'h2345_6789);
    check("fill lock", 64'h1, {63'h0, fill_lock_out});
    check("tag lock on fill", 64'h1, {63'h0, tag_lock_out});
    fill(1'b1, 64'h2, 14'h0, 32'h0111_1111);
    rd_reg(3'h2, 5'h0);
    check("syndrome", 64'h27cf, rd);
    rd_reg(3'h4, 5'h0);
    check("fill status", 64'h23, {57'h0, rd[14:8]});
    wr_reg(3'h1, 5'h0, 64'hffff_ffff_ffff_ffff);
    rd_reg(3'h1, 5'h0);
    check("fill address", 64'h8d15_9e24, rd);
    check("fill unlock", 64'h0, {63'h0, fill_lock_out});
    fill(1'b1, 64'h0, 14'h2001, 32'h0000_0040);
    rd_reg(3'h2, 5'h0);
    check("check bit syndrome", 64'h2001, rd);
    rd_reg(3'h1, 5'h0);
    check("second address", 64'h100, rd);
  endtask

  task automatic test_parity();
    fill(1'b0, 64'h0000_0000_0000_0001, 14'h0, 32'h0000_0008);
    rd_reg(3'h2, 5'h0);
    check("parity low", 64'h0001, rd);
    rd_reg(3'h1, 5'h0);
    @(posedge core_clk);
    fill_istream <= 1'b1;
    fill(1'b0, 64'h0000_0001_0000_0000, 14'h0, 32'h0000_0010);
    fill(1'b0, 64'h0000_0000_0000_0001, 14'h0, 32'h0000_0020);
    rd_reg(3'h2, 5'h0);
    check("parity high", 64'h0080, rd);
    rd_reg(3'h4, 5'h0);
    check("parity status", 64'h6c, {57'h0, rd[14:8]});
    rd_reg(3'h1, 5'h0);
    check("parity address", 64'h40, rd);
  endtask

  task automatic test_tag();
    wr_reg(3'h3, 5'h0, 64'h0);
    check("tag unlock", 64'h0, {63'h0, tag_lock_out});
    @(posedge core_clk);
    pins <= 5'b10110;
    offchip_cache_size <= 3'h3;
    repeat (6) @(posedge core_clk);
    probe(21'h1a5a5, 1'b1, 1'b1, 1'b0);
    check("tag lock", 64'h1, {63'h0, tag_lock_out});
    probe(21'h0f0f0, 1'b0, 1'b0, 1'b0);
    snap(21'h1a5a5, 1'b1);
    wr_reg(3'h3, 5'h0, 64'h0);
    @(posedge core_clk);
    pins <= 5'b01001;
    offchip_cache_size <= 3'h0;
    repeat (6) @(posedge core_clk);
    probe(21'h12345, 1'b0, 1'b0, 1'b0);
    check("no lock", 64'h0, {63'h0, tag_lock_out});
    snap(21'h12345, 1'b0);
    probe(21'h00abc, 1'b1, 1'b0, 1'b1);
    check("control lock", 64'h1, {63'h0, tag_lock_out});
    snap(21'h00abc, 1'b1);
  endtask

  ////////////////////////////////////////
  // Verdict, watchdog and main sequence
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Whole run needs under a thousand cycles; five thousand leaves ample slack
  initial
  begin
    #(40 * 5000);
    fails++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    check("locks after reset", 64'h0, {62'h0, fill_lock_out, tag_lock_out});
    test_regs();
    test_ecc();
    test_parity();
    test_tag();
    finish_test();
  end
endmodule // cfec_top_bench
